/* bench/osw_oscillator_switch_monitor.sv */
// Port assertions for the oscillator switch block.
// Assumes a bind onto osw_oscillator_switch.
`timescale 1ns/1ps
module osw_oscillator_switch_monitor #(parameter int SWITCH_CYCLES_P = 2) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [osw_pkg::ADDR_W-1:0] regAddr,
  input wire logic [osw_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [osw_pkg::DATA_W-1:0] regRdata,
  input wire logic failDetect,
  input wire logic oscFailTrap,
  input wire logic [2:0] currentOsc,
  input wire logic irq
);
  import osw_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  trap_cause_a: assert property (oscFailTrap |-> $past(failDetect || regWrite) || $past(failDetect || regWrite, 2))
    else $error("trap without cause");
  trap_pulse_a: assert property (oscFailTrap |=> !oscFailTrap)
    else $error("trap longer than one cycle");
  fail_read_a: assert property ($past(regRead && regAddr == OSC_CONTROL_ADDR) && $past(failDetect, 2) |-> regRdata[3])
    else $error("fail flag not seen");
  res_zero_a: assert property ($past(regRead && regAddr == OSC_CONTROL_ADDR) |-> (regRdata & 16'h0016) == 16'h0000)
    else $error("unused bits not zero");
  // Exact latency: a late or early source change fails here
  switch_cause_a: assert property ($changed(currentOsc) |->
    $past(regWrite && regAddr == OSC_CONTROL_ADDR && regWdata[0], SWITCH_CYCLES_P + 1)
    && $past(regWrite && regWdata == UNLOCK_KEY2, SWITCH_CYCLES_P + 2))
    else $error("source change without unlocked request");
  no_pll_hop_a: assert property ($past(currentOsc) inside {3'h1, 3'h3} && currentOsc inside {3'h1, 3'h3} |-> $stable(currentOsc))
    else $error("direct hop between pll sources");
  done_read_a: assert property ($changed(currentOsc) && regRead && regAddr == OSC_CONTROL_ADDR |=> !regRdata[0])
    else $error("request bit set after switch");
  unmapped_zero_a: assert property ($past(regRead && regAddr > CUR_OSC_ADDR) |-> regRdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule : osw_oscillator_switch_monitor

/* bench/osw_oscillator_switch_tb.sv */
// Self-checking bench for the oscillator switch block.
// Assumes the package and design are compiled first.
`timescale 1ns/1ps
`define CK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module osw_oscillator_switch_tb;
  import osw_pkg::*;
  logic mclk = 0, srst = 1, regWrite = 0, regRead = 0, failDetect = 0, oscFailTrap, irq;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000, regRdata;
  logic [2:0] currentOsc;
  int fail_count = 0, comparisons = 0, traps = 0;
  // Short switch time keeps the run small
  osw_oscillator_switch #(.SWITCH_CYCLES_P(2)) i_osw_oscillator_switch (.mclk(mclk), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .failDetect(failDetect),
    .oscFailTrap(oscFailTrap), .currentOsc(currentOsc), .irq(irq));
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) if (oscFailTrap === 1'b1) traps++;
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk); regAddr <= a; regWdata <= d; regWrite <= 1; regRead <= 0;
  endtask : wr
  task idle(input int n);
    @(posedge mclk); regWrite <= 0; regRead <= 0;
    repeat (n) @(posedge mclk);
  endtask : idle
  // Any other access between the keys and the write relocks
  task ul(input logic [15:0] v);
    wr(UNLOCK_ADDR, UNLOCK_KEY1); wr(UNLOCK_ADDR, UNLOCK_KEY2); wr(OSC_CONTROL_ADDR, v); idle(6);
  endtask : ul
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk); regAddr <= a; regRead <= 1; regWrite <= 0;
    @(posedge mclk); regRead <= 0;
    #1 `CK("rdata", e, regRdata)
  endtask : rd
  task final_report;
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    #4000 fail_count++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 0;
    wr(OSC_CONTROL_ADDR, 16'h0201); idle(6); rd(OSC_CONTROL_ADDR, 16'h0000);
    ul(16'h0201); rd(OSC_CONTROL_ADDR, 16'h2200);
    ul(16'h0216); rd(OSC_CONTROL_ADDR, 16'h2200);
    ul(16'h0301); ul(16'h0101); rd(OSC_CONTROL_ADDR, 16'h3100);
    rd(IRQ_STATUS_ADDR, 16'h0006);
    ul(16'h0001); ul(16'h0101); `CK("osc", 3'h1, currentOsc)
    wr(IRQ_ENABLE_ADDR, 16'h0001); idle(1);
    @(posedge mclk); failDetect <= 1;
    @(posedge mclk); failDetect <= 0;
    idle(2); `CK("irq", 1'b1, irq)
    rd(OSC_CONTROL_ADDR, 16'h1108);
    ul(16'h0100); wr(IRQ_CLEAR_ADDR, 16'h0007); idle(2); `CK("irq", 1'b0, irq)
    ul(16'h0108); `CK("traps", 2, traps)
    wr(UNLOCK_ADDR, UNLOCK_KEY1); wr(UNLOCK_ADDR, UNLOCK_KEY2);
    rd(IRQ_ENABLE_ADDR, 16'h0001);
    wr(OSC_CONTROL_ADDR, 16'h0001); idle(6); rd(OSC_CONTROL_ADDR, 16'h1108);
    rd(CUR_OSC_ADDR, 16'h0001);
    rd(4'hf, 16'h0000);
    final_report;
  end
endmodule : osw_oscillator_switch_tb
bind osw_oscillator_switch osw_oscillator_switch_monitor #(.SWITCH_CYCLES_P(SWITCH_CYCLES_P)) i_mon (.mclk(mclk),
  .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .failDetect(failDetect), .oscFailTrap(oscFailTrap), .currentOsc(currentOsc), .irq(irq));

/* hw/osw_oscillator_switch.sv */
// Oscillator control register with switch sequencing, fail flag and unlock.
// Assumes failDetect is one cycle pulse from the clock monitor, synchronous.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
module osw_oscillator_switch #(
  parameter int SWITCH_CYCLES_P = osw_pkg::SWITCH_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [osw_pkg::ADDR_W-1:0] regAddr,
  input wire logic [osw_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [osw_pkg::DATA_W-1:0] regRdata,
  input wire logic failDetect,
  output logic oscFailTrap,
  output logic [2:0] currentOsc,
  output logic irq
);
  import osw_pkg::*;

  osw_lock_type lockState, next_lockState;
  logic clockFailFlag, next_clockFailFlag;
  logic switchRequest, next_switchRequest;
  logic [2:0] newOscSelect, next_newOscSelect;
  logic [2:0] next_currentOsc;
  logic [7:0] switchCount, next_switchCount;
  logic [IRQ_N-1:0] irqStatus, next_irqStatus;
  logic [IRQ_N-1:0] irqEnable, next_irqEnable;
  logic [DATA_W-1:0] next_regRdata;
  logic next_oscFailTrap;
  logic next_irq;
  logic ctlWrite;
  logic forbidden;
  logic [IRQ_N-1:0] events;

  function automatic logic isPll(input logic [2:0] src);
    isPll = (src == SRC_RC_PLL) || (src == SRC_PRI_PLL);
  endfunction : isPll

  // Only a write that is the next access after the key pair reaches the control register; idle cycles between do not relock
  assign ctlWrite = regWrite && regAddr == OSC_CONTROL_ADDR && lockState == UNLOCKED;
  // PLL to a different PLL is refused; software must pass through a non-PLL source (fast RC or primary)
  assign forbidden = isPll(currentOsc) && isPll(regWdata[NEW_OSC_LSB +: 3])
    && regWdata[NEW_OSC_LSB +: 3] != currentOsc;

  always_comb begin
    next_lockState = lockState;
    if (regWrite || regRead) begin
      next_lockState = LOCKED;
      if (regWrite && regAddr == UNLOCK_ADDR && regWdata == UNLOCK_KEY1) begin
        next_lockState = KEY1_SEEN;
      end else if (regWrite && regAddr == UNLOCK_ADDR && regWdata == UNLOCK_KEY2 && lockState == KEY1_SEEN) begin
        next_lockState = UNLOCKED;
      end
    end
  end

  always_comb begin
    next_clockFailFlag = clockFailFlag;
    next_switchRequest = switchRequest;
    next_newOscSelect = newOscSelect;
    next_currentOsc = currentOsc;
    next_switchCount = switchCount;
    next_oscFailTrap = 1'b0;
    events = '0;
    if (ctlWrite) begin
      next_newOscSelect = regWdata[NEW_OSC_LSB +: 3];
      // Zero clears; a one sets the flag and, only if it was clear, traps and raises IRQ_FAIL
      next_clockFailFlag = regWdata[CLOCK_FAIL_BIT];
      if (regWdata[CLOCK_FAIL_BIT] && !clockFailFlag) begin
        next_oscFailTrap = 1'b1;
        events[IRQ_FAIL] = 1'b1;
      end
      if (regWdata[SWITCH_REQ_BIT] && !switchRequest) begin
        if (forbidden) begin
          events[IRQ_REFUSED] = 1'b1;
        end else begin
          next_switchRequest = 1'b1;
          next_switchCount = 8'(SWITCH_CYCLES_P);
        end
      end
    end
    if (switchRequest) begin
      if (switchCount <= 8'h01) begin
        next_switchRequest = 1'b0;
        next_currentOsc = newOscSelect;
        events[IRQ_DONE] = 1'b1;
      end else begin
        next_switchCount = switchCount - 8'h01;
      end
    end
    // Monitor detection wins over a same-cycle clear
    if (failDetect) begin
      next_clockFailFlag = 1'b1;
      next_oscFailTrap = !clockFailFlag;
      events[IRQ_FAIL] = 1'b1;
    end
  end

  always_comb begin
    next_irqEnable = irqEnable;
    next_irqStatus = irqStatus;
    if (regWrite && regAddr == IRQ_ENABLE_ADDR) begin
      next_irqEnable = regWdata[IRQ_N-1:0];
    end
    if (regWrite && regAddr == IRQ_CLEAR_ADDR) begin
      next_irqStatus = irqStatus & ~regWdata[IRQ_N-1:0];
    end
    // Set wins over clear
    next_irqStatus = next_irqStatus | events;
    next_irq = |(next_irqStatus & next_irqEnable);
  end

  always_comb begin
    next_regRdata = '0;
    if (regRead) begin
      unique case (regAddr)
        OSC_CONTROL_ADDR: begin
          // Bits 4, 2 and 1 are not stored and read zero
          next_regRdata[SWITCH_REQ_BIT] = switchRequest;
          next_regRdata[CLOCK_FAIL_BIT] = clockFailFlag;
          next_regRdata[NEW_OSC_LSB +: 3] = newOscSelect;
          next_regRdata[CUR_OSC_LSB +: 3] = currentOsc;
        end
        IRQ_STATUS_ADDR: next_regRdata[IRQ_N-1:0] = irqStatus;
        IRQ_ENABLE_ADDR: next_regRdata[IRQ_N-1:0] = irqEnable;
        CUR_OSC_ADDR: next_regRdata[2:0] = currentOsc;
        default: next_regRdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lockState <= LOCKED;
      clockFailFlag <= 1'b0;
      switchRequest <= 1'b0;
      newOscSelect <= SRC_RESET;
      currentOsc <= SRC_RESET;
      switchCount <= 8'h00;
      irqStatus <= '0;
      irqEnable <= '0;
      regRdata <= '0;
      oscFailTrap <= 1'b0;
      irq <= 1'b0;
    end else begin
      lockState <= next_lockState;
      clockFailFlag <= next_clockFailFlag;
      switchRequest <= next_switchRequest;
      newOscSelect <= next_newOscSelect;
      currentOsc <= next_currentOsc;
      switchCount <= next_switchCount;
      irqStatus <= next_irqStatus;
      irqEnable <= next_irqEnable;
      regRdata <= next_regRdata;
      oscFailTrap <= next_oscFailTrap;
      irq <= next_irq;
    end
  end
endmodule : osw_oscillator_switch

/* hw/osw_pkg.sv */
// Constants, register map and state types for the oscillator switch block.
// Assumes a plain register port with read data one cycle after the strobe.
package osw_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OSC_CONTROL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] CUR_OSC_ADDR = 4'h5;
  localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 16'h0046;
  localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 16'h0057;
  localparam int SWITCH_REQ_BIT = 0;
  localparam int CLOCK_FAIL_BIT = 3;
  localparam int NEW_OSC_LSB = 8;
  localparam int CUR_OSC_LSB = 12;
  localparam logic [2:0] SRC_FAST_RC = 3'h0;
  localparam logic [2:0] SRC_RC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam int SWITCH_TIME_NS = 64;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IRQ_FAIL = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_N = 3;
  typedef enum logic [1:0] {LOCKED, KEY1_SEEN, UNLOCKED} osw_lock_type;
endpackage : osw_pkg
